// >>> lgc_pkg.sv
/*
  Holds the register map, field layout, reset values and clock rate table of the
  line unit global clock configuration block.
  Assumes an 8-bit register port with a 16-bit address and one clock domain.
*/
package lgc_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 8;
  localparam logic [15:0] ADDR_CTL_TWO    = 16'h0fe2;
  localparam logic [15:0] ADDR_CTL_THREE  = 16'h0fe9;
  localparam logic [15:0] ADDR_CLK_SEL    = 16'h0fea;

  // ==========================================================================
  // Fields and reset values
  // ==========================================================================
  localparam int          TWO_FORCE_BIT   = 7;
  localparam int          SEL_CODE_LSB    = 0;
  localparam int          SEL_CODE_W      = 4;
  localparam logic [7:0]  RST_CTL_TWO     = 8'h00;
  localparam logic [7:0]  RST_CTL_THREE   = 8'h00;
  localparam logic [3:0]  RST_RATE_CODE   = 4'h1;
  localparam logic [3:0]  SEL_UPPER_ZERO  = 4'h0;
  localparam logic [7:0]  RD_IDLE         = 8'h00;

  // ==========================================================================
  // Master rate codes and rates in kHz
  // ==========================================================================
  localparam logic [3:0]  CODE_2048_A     = 4'h0;
  localparam logic [3:0]  CODE_1544_A     = 4'h1;
  localparam logic [3:0]  CODE_RSVD_LO    = 4'h2;
  localparam logic [3:0]  CODE_RSVD_HI    = 4'h7;
  localparam logic [3:0]  CODE_4096       = 4'h8;
  localparam logic [3:0]  CODE_3088       = 4'h9;
  localparam logic [3:0]  CODE_8192       = 4'ha;
  localparam logic [3:0]  CODE_6176       = 4'hb;
  localparam logic [3:0]  CODE_16384      = 4'hc;
  localparam logic [3:0]  CODE_12352      = 4'hd;
  localparam logic [3:0]  CODE_2048_B     = 4'he;
  localparam logic [3:0]  CODE_1544_B     = 4'hf;
  localparam logic [14:0] KHZ_1544        = 15'h0608;
  localparam logic [14:0] KHZ_2048        = 15'h0800;
  localparam logic [14:0] KHZ_3088        = 15'h0c10;
  localparam logic [14:0] KHZ_4096        = 15'h1000;
  localparam logic [14:0] KHZ_6176        = 15'h1820;
  localparam logic [14:0] KHZ_8192        = 15'h2000;
  localparam logic [14:0] KHZ_12352       = 15'h3040;
  localparam logic [14:0] KHZ_16384       = 15'h4000;
  localparam logic [14:0] KHZ_NONE        = 15'h0000;
  localparam logic [1:0]  MULT_X1         = 2'h0;
  localparam logic [1:0]  MULT_X2         = 2'h1;
  localparam logic [1:0]  MULT_X4         = 2'h2;
  localparam logic [1:0]  MULT_X8         = 2'h3;

  // Decoded view of the master clock rate.
  typedef struct packed {
    logic        valid;
    logic        is_e1;
    logic [1:0]  mult;
    logic [14:0] khz;
  } lgc_rate_s;

  localparam lgc_rate_s RATE_RESET = '{valid: 1'b1, is_e1: 1'b0, mult: 2'h0, khz: 15'h0608};

endpackage

// >>> lgc_top.sv
/*
  Holds the global line unit configuration registers and the master clock rate
  decode. Assumes a register master on clk that keeps one-cycle strobes and never
  raises read and write together; the master clock pin rate is set by the system.
*/
// Operation
// - Control two bits 6-0 unused, reset zero; software writes zero to bit 7.
// - Control three is eight bits of plain storage resetting to zero.
// - Clock select bits 3-0 hold the rate code, reset 0001; bits 7-4 reserved zero.
// - Code 0000 is 2.048 MHz, 0001 is 1.544 MHz, 0010-0111 reserved.
// - Codes 1000-1111 map to 4.096, 3.088, 8.192, 6.176, 16.384, 12.352, 2.048, 1.544 MHz.
`timescale 1ns/10ps
module lgc_top (
  input  wire logic                  clk,            // 200 MHz system clock.
  input  wire logic                  rst,            // Asynchronous reset, active high.
  input  wire logic [15:0]           addr,           // Register byte address.
  input  wire logic [7:0]            wr_data,        // Register write data.
  input  wire logic                  wr_en,          // Write strobe, one cycle.
  input  wire logic                  rd_en,          // Read strobe, one cycle.
  output logic      [7:0]            rd_data,        // Read data, cycle after rd_en.
  output logic      [3:0]            master_rate_code, // Programmed rate code.
  output lgc_pkg::lgc_rate_s         master_rate,    // Decoded master clock rate.
  output logic                       cfg_error       // Reserved code or bit 7 set.
);

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // Select lines for each register.
  wire hit_two   = (addr == lgc_pkg::ADDR_CTL_TWO);
  wire hit_three = (addr == lgc_pkg::ADDR_CTL_THREE);
  wire hit_sel   = (addr == lgc_pkg::ADDR_CLK_SEL);
  wire wr_two    = wr_en && hit_two;
  wire wr_three  = wr_en && hit_three;
  wire wr_sel    = wr_en && hit_sel;

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0]         ctl_two_q;
  logic [7:0]         ctl_three_q;
  logic [3:0]         code_q;
  logic [7:0]         rd_data_q;
  lgc_pkg::lgc_rate_s rate_q;
  logic               cfg_error_q;
  logic [7:0]         rd_data_d;
  lgc_pkg::lgc_rate_s rate_d;
  logic               code_rsvd;

  // Register storage; reserved select bits are not stored and read zero.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_two_q   <= lgc_pkg::RST_CTL_TWO;
      ctl_three_q <= lgc_pkg::RST_CTL_THREE;
      code_q      <= lgc_pkg::RST_RATE_CODE;
    end
    else
    begin
      if (wr_two)
      begin
        ctl_two_q <= wr_data;
      end
      if (wr_three)
      begin
        ctl_three_q <= wr_data;
      end
      if (wr_sel)
      begin
        code_q <= wr_data[lgc_pkg::SEL_CODE_LSB +: lgc_pkg::SEL_CODE_W];
      end
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  // Read data for the addressed register; unmapped addresses read zero.
  assign rd_data_d = !rd_en    ? lgc_pkg::RD_IDLE :
                     hit_two   ? ctl_two_q :
                     hit_three ? ctl_three_q :
                     hit_sel   ? {lgc_pkg::SEL_UPPER_ZERO, code_q} :
                                 lgc_pkg::RD_IDLE;

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_q <= lgc_pkg::RD_IDLE;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end

  // ==========================================================================
  // Master clock rate decode
  // ==========================================================================
  // Maps a rate code to its rate; reserved codes give an invalid, zero rate.
  function automatic lgc_pkg::lgc_rate_s decode_rate(input logic [3:0] code);
    lgc_pkg::lgc_rate_s r;
    r = '{valid: 1'b1, is_e1: 1'b0, mult: lgc_pkg::MULT_X1, khz: lgc_pkg::KHZ_NONE};
    case (code)
      lgc_pkg::CODE_2048_A: r = '{1'b1, 1'b1, lgc_pkg::MULT_X1, lgc_pkg::KHZ_2048};
      lgc_pkg::CODE_1544_A: r = '{1'b1, 1'b0, lgc_pkg::MULT_X1, lgc_pkg::KHZ_1544};
      lgc_pkg::CODE_4096:   r = '{1'b1, 1'b1, lgc_pkg::MULT_X2, lgc_pkg::KHZ_4096};
      lgc_pkg::CODE_3088:   r = '{1'b1, 1'b0, lgc_pkg::MULT_X2, lgc_pkg::KHZ_3088};
      lgc_pkg::CODE_8192:   r = '{1'b1, 1'b1, lgc_pkg::MULT_X4, lgc_pkg::KHZ_8192};
      lgc_pkg::CODE_6176:   r = '{1'b1, 1'b0, lgc_pkg::MULT_X4, lgc_pkg::KHZ_6176};
      lgc_pkg::CODE_16384:  r = '{1'b1, 1'b1, lgc_pkg::MULT_X8, lgc_pkg::KHZ_16384};
      lgc_pkg::CODE_12352:  r = '{1'b1, 1'b0, lgc_pkg::MULT_X8, lgc_pkg::KHZ_12352};
      lgc_pkg::CODE_2048_B: r = '{1'b1, 1'b1, lgc_pkg::MULT_X1, lgc_pkg::KHZ_2048};
      lgc_pkg::CODE_1544_B: r = '{1'b1, 1'b0, lgc_pkg::MULT_X1, lgc_pkg::KHZ_1544};
      default:              r = '{1'b0, 1'b0, lgc_pkg::MULT_X1, lgc_pkg::KHZ_NONE};
    endcase
    return r;
  endfunction

  // Decoded rate and error flag for the current code.
  assign rate_d    = decode_rate(code_q);
  assign code_rsvd = (code_q >= lgc_pkg::CODE_RSVD_LO) && (code_q <= lgc_pkg::CODE_RSVD_HI);

  // Registered decode; the error also covers a one written to the force bit.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rate_q      <= lgc_pkg::RATE_RESET;
      cfg_error_q <= 1'b0;
    end
    else
    begin
      rate_q      <= rate_d;
      cfg_error_q <= code_rsvd || ctl_two_q[lgc_pkg::TWO_FORCE_BIT];
    end
  end

  // Outputs come straight from flip-flops.
  assign rd_data          = rd_data_q;
  assign master_rate_code = code_q;
  assign master_rate      = rate_q;
  assign cfg_error        = cfg_error_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_two_write_read: assert property (@(posedge clk) disable iff (rst)
    (wr_two ##1 (rd_en && hit_two && !wr_en)) |=> (rd_data == $past(wr_data, 2)))
    else $error("Control two did not read back the written value.");

  a_three_store: assert property (@(posedge clk) disable iff (rst)
    wr_three |=> (ctl_three_q == $past(wr_data)) && (rd_data == lgc_pkg::RD_IDLE || $past(rd_en)))
    else $error("Control three did not store the written value.");

  a_sel_read_upper: assert property (@(posedge clk) disable iff (rst)
    (rd_en && hit_sel) |=> (rd_data[7:4] == 4'h0) && (rd_data[3:0] == $past(code_q)))
    else $error("Clock select read returned wrong code or nonzero upper bits.");

  a_sel_store_code: assert property (@(posedge clk) disable iff (rst)
    wr_sel |=> (master_rate_code == $past(wr_data[3:0])))
    else $error("Rate code did not take the written low nibble.");

  a_rate_base_codes: assert property (@(posedge clk) disable iff (rst)
    ($past(code_q) == 4'h0 && !$past(rst)) |-> (master_rate.khz == 15'h0800) && master_rate.valid)
    else $error("Code zero did not decode to 2048 kHz.");

  a_rate_high_codes: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'hc) ##1 (code_q == 4'hc) |-> (master_rate.khz == 15'h4000) && master_rate.is_e1)
    else $error("Code 1100 did not decode to 16384 kHz.");

  a_rate_tail_codes: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'hd) |=> (master_rate.khz == 15'h3040) && (master_rate.mult == 2'h3))
    else $error("Code 1101 did not decode to 12352 kHz.");

  a_reserved_error: assert property (@(posedge clk) disable iff (rst)
    (code_q inside {[4'h2:4'h7]}) |=> cfg_error && !master_rate.valid)
    else $error("Reserved rate code did not raise the configuration error.");

  a_force_bit_error: assert property (@(posedge clk) disable iff (rst)
    (wr_two && wr_data[7]) |=> ##1 cfg_error)
    else $error("A one in the force bit did not raise the configuration error.");

  // ==========================================================================
  // Assertions on the full decode table
  // ==========================================================================
  // Each supported code must give its whole decoded word one cycle later.
  a_rate_code_zero: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'h0) |=> (master_rate == 19'h60800))
    else $error("Code 0000 did not give the full 2048 kHz decode.");

  a_rate_code_one: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'h1) |=> (master_rate == 19'h40608))
    else $error("Code 0001 did not give the full 1544 kHz decode.");

  a_rate_code_eight: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'h8) |=> (master_rate == 19'h69000))
    else $error("Code 1000 did not give the full 4096 kHz decode.");

  a_rate_code_nine: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'h9) |=> (master_rate == 19'h48c10))
    else $error("Code 1001 did not give the full 3088 kHz decode.");

  a_rate_code_ten: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'ha) |=> (master_rate == 19'h72000))
    else $error("Code 1010 did not give the full 8192 kHz decode.");

  a_rate_code_eleven: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'hb) |=> (master_rate == 19'h51820))
    else $error("Code 1011 did not give the full 6176 kHz decode.");

  a_rate_code_twelve: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'hc) |=> (master_rate == 19'h7c000))
    else $error("Code 1100 did not give the full 16384 kHz decode.");

  a_rate_code_thirteen: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'hd) |=> (master_rate == 19'h5b040))
    else $error("Code 1101 did not give the full 12352 kHz decode.");

  a_rate_code_fourteen: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'he) |=> (master_rate == 19'h60800))
    else $error("Code 1110 did not give the full 2048 kHz decode.");

  a_rate_code_fifteen: assert property (@(posedge clk) disable iff (rst)
    (code_q == 4'hf) |=> (master_rate == 19'h40608))
    else $error("Code 1111 did not give the full 1544 kHz decode.");

  a_valid_rate_flag: assert property (@(posedge clk) disable iff (rst)
    !(code_q inside {[4'h2:4'h7]}) |=> master_rate.valid)
    else $error("A supported code gave an invalid rate.");

  a_valid_rate_nonzero: assert property (@(posedge clk) disable iff (rst)
    master_rate.valid |-> (master_rate.khz != 15'h0000))
    else $error("A valid rate carried a zero frequency.");

  // ==========================================================================
  // Assertions on reserved codes and the configuration error
  // ==========================================================================
  // The error must follow its two causes exactly, with nothing else raising it.
  a_rsvd_rate_zero: assert property (@(posedge clk) disable iff (rst)
    (code_q inside {[4'h2:4'h7]}) |=> (master_rate == 19'h00000))
    else $error("A reserved code did not give an all-zero decode.");

  a_rsvd_code_kept: assert property (@(posedge clk) disable iff (rst)
    (wr_sel && (wr_data[3:0] == 4'h5)) |=> (master_rate_code == 4'h5))
    else $error("A reserved code was not kept as written.");

  a_clean_no_error: assert property (@(posedge clk) disable iff (rst)
    (!(code_q inside {[4'h2:4'h7]}) && !ctl_two_q[7]) |=> !cfg_error)
    else $error("The configuration error rose with no cause.");

  a_error_needs_cause: assert property (@(posedge clk) disable iff (rst)
    cfg_error |-> ($past(code_q inside {[4'h2:4'h7]}) || $past(ctl_two_q[7])))
    else $error("The configuration error stood with no cause one cycle before.");

  a_force_bit_hold: assert property (@(posedge clk) disable iff (rst)
    ctl_two_q[7] |=> cfg_error)
    else $error("The configuration error fell while the force bit was set.");

  // ==========================================================================
  // Assertions on register storage
  // ==========================================================================
  // Registers change only on a write to their own address.
  a_two_store: assert property (@(posedge clk) disable iff (rst)
    wr_two |=> (ctl_two_q == $past(wr_data)))
    else $error("Control two did not store the written value.");

  a_two_hold: assert property (@(posedge clk) disable iff (rst)
    !wr_two |=> $stable(ctl_two_q))
    else $error("Control two changed without a write.");

  a_three_hold: assert property (@(posedge clk) disable iff (rst)
    !wr_three |=> $stable(ctl_three_q))
    else $error("Control three changed without a write.");

  a_rate_code_hold: assert property (@(posedge clk) disable iff (rst)
    !wr_sel |=> $stable(master_rate_code))
    else $error("The rate code changed without a write.");

  // ==========================================================================
  // Assertions on the read path
  // ==========================================================================
  // Read data stand one cycle after the strobe and are zero otherwise.
  a_rd_idle_zero: assert property (@(posedge clk) disable iff (rst)
    !rd_en |=> (rd_data == 8'h00))
    else $error("Read data were not zero outside a read.");

  a_rd_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    (rd_en && !hit_two && !hit_three && !hit_sel) |=> (rd_data == 8'h00))
    else $error("An unmapped read returned nonzero data.");

  a_two_read_value: assert property (@(posedge clk) disable iff (rst)
    (rd_en && hit_two) |=> (rd_data == $past(ctl_two_q)))
    else $error("Control two read returned the wrong value.");

  a_three_read_value: assert property (@(posedge clk) disable iff (rst)
    (rd_en && hit_three) |=> (rd_data == $past(ctl_three_q)))
    else $error("Control three read returned the wrong value.");

  a_sel_read_full: assert property (@(posedge clk) disable iff (rst)
    (rd_en && hit_sel) |=> (rd_data == {4'h0, $past(master_rate_code)}))
    else $error("Clock select read returned the wrong byte.");

endmodule // lgc_top

// >>> lgc_top_test.sv
/*
  Self-checking testbench of the line unit global clock configuration block.
  Assumes the register port and offsets of lgc_pkg and one 200 MHz clock.
*/
`timescale 1ns/10ps
module lgc_top_test;
  // ==========================================================================
  // Signals and design instance
  // ==========================================================================
  logic               clk;
  logic               rst;
  logic [15:0]        addr;
  logic [7:0]         wr_data;
  logic               wr_en;
  logic               rd_en;
  logic [7:0]         rd_data;
  logic [3:0]         master_rate_code;
  lgc_pkg::lgc_rate_s master_rate;
  logic               cfg_error;
  int                 fails;
  int                 num_checks;
  // Expected decode per code: {valid, is_e1, mult, khz}; reserved codes decode to zero.
  logic [18:0]        rows [16] = '{19'h60800, 19'h40608, 19'h00000, 19'h00000,
                                    19'h00000, 19'h00000, 19'h00000, 19'h00000,
                                    19'h69000, 19'h48c10, 19'h72000, 19'h51820,
                                    19'h7c000, 19'h5b040, 19'h60800, 19'h40608};

  lgc_top i_dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
                 .rd_en(rd_en), .rd_data(rd_data), .master_rate_code(master_rate_code),
                 .master_rate(master_rate), .cfg_error(cfg_error));

  // Clock of 5 ns period.
  always #2.5 clk = ~clk;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input string name, input logic [18:0] seen, input logic [18:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write strobe, then waits for the register to take it.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  // One-cycle read strobe; the data are looked at in the following cycle only.
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk("rd_data", 19'(rd_data), 19'(exp));
  endtask

  // Checks the state that reset must leave, and the register reset values.
  task automatic chk_reset();
    chk("code", 19'(master_rate_code), 19'h1);
    chk("rate", master_rate, 19'h40608);
    chk("error", 19'(cfg_error), 19'h0);
    rd(lgc_pkg::ADDR_CTL_TWO, 8'h00);
    rd(lgc_pkg::ADDR_CTL_THREE, 8'h00);
    rd(lgc_pkg::ADDR_CLK_SEL, 8'h01);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  // Watchdog so a hang still ends in the closing report.
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial
  begin
    clk = 1'b0; rst = 1'b1; addr = 16'h0000; wr_data = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
    fails = 0; num_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_reset();
    $display("test reset done");
    // Every rate code: decode one cycle after the write edge, then read back.
    for (int i = 0; i < 16; i++)
    begin
      wr(lgc_pkg::ADDR_CLK_SEL, {4'h0, i[3:0]});
      @(posedge clk);
      #1;
      chk("code", 19'(master_rate_code), 19'(i[3:0]));
      chk("rate", master_rate, rows[i]);
      chk("error", 19'(cfg_error), 19'((i >= 2) && (i <= 7)));
      rd(lgc_pkg::ADDR_CLK_SEL, {4'h0, i[3:0]});
    end
    $display("test rate codes done");
    // Reserved upper nibble is dropped; code 0xf still decodes.
    wr(lgc_pkg::ADDR_CLK_SEL, 8'hff);
    rd(lgc_pkg::ADDR_CLK_SEL, 8'h0f);
    chk("rate", master_rate, rows[15]);
    // Control two: unused bits store, bit 7 set flags an error until cleared.
    wr(lgc_pkg::ADDR_CTL_TWO, 8'h7f);
    rd(lgc_pkg::ADDR_CTL_TWO, 8'h7f);
    chk("error", 19'(cfg_error), 19'h0);
    wr(lgc_pkg::ADDR_CTL_TWO, 8'h80);
    rd(lgc_pkg::ADDR_CTL_TWO, 8'h80);
    chk("error", 19'(cfg_error), 19'h1);
    wr(lgc_pkg::ADDR_CTL_TWO, 8'h00);
    @(posedge clk);
    #1;
    chk("error", 19'(cfg_error), 19'h0);
    // Control three is plain storage with no effect on the rate.
    wr(lgc_pkg::ADDR_CTL_THREE, 8'ha5);
    rd(lgc_pkg::ADDR_CTL_THREE, 8'ha5);
    chk("rate", master_rate, rows[15]);
    // Unmapped address neither stores nor disturbs the clock select.
    wr(16'h0fe3, 8'h55);
    rd(16'h0fe3, 8'h00);
    rd(lgc_pkg::ADDR_CLK_SEL, 8'h0f);
    $display("test register access done");
    // Second reset in mid-run restores every default.
    wr(lgc_pkg::ADDR_CLK_SEL, 8'h03);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_reset();
    $display("test second reset done");
    report_and_stop();
  end
endmodule // lgc_top_test
